// ---- core/qpc_pkg.sv ----
// Shared constants, types and helpers of the quadrature position counter.
// Assumes one 200 MHz clock; encoder and bus inputs are synchronous to it.
`default_nettype none

package qpc_pkg;

  localparam int unsigned COUNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FILT_STAGES = 3;
  localparam int unsigned CLK_PERIOD_NS = 5;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] AB_RESET = 2'h0;
  localparam logic [FILT_STAGES-1:0] FILT_RESET = 3'h0;

  // Bit positions of the two bytes inside the latched position
  localparam int unsigned HI_BYTE_LSB = 8;
  localparam int unsigned LO_BYTE_LSB = 0;

  // Read inhibit sequence, one-hot
  typedef enum logic [2:0] {
    QPC_INH_IDLE = 3'h1,
    QPC_INH_HIGH = 3'h2,
    QPC_INH_LOW  = 3'h4
  } qpc_inh_e;

  // Channel pair {a, b} one step forward when a leads b
  function automatic logic [1:0] qpc_next_up(input logic [1:0] ab);
    logic [1:0] nxt;
    nxt = 2'h0;
    unique case (ab)
      2'h0: nxt = 2'h2;
      2'h2: nxt = 2'h3;
      2'h3: nxt = 2'h1;
      2'h1: nxt = 2'h0;
    endcase
    return nxt;
  endfunction

  // Byte of the position chosen by the byte select (0 high, 1 low)
  function automatic logic [BYTE_W-1:0] qpc_byte(input logic [COUNT_W-1:0] pos, input logic sel);
    return sel ? pos[LO_BYTE_LSB +: BYTE_W] : pos[HI_BYTE_LSB +: BYTE_W];
  endfunction

endpackage

`default_nettype wire

// ---- core/qpc_filter.sv ----
// Three-sample digital noise filter for one encoder channel.
// Assumes the channel input is already synchronous to clock.
`default_nettype none

module qpc_filter (
  input wire logic clock,
  input wire logic srst,
  input wire logic chan_in,
  output logic chan_out
);
  import qpc_pkg::*;

  logic [FILT_STAGES-1:0] hist_reg;
  logic [FILT_STAGES-1:0] hist_next;
  logic out_reg;
  logic out_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    hist_next = {hist_reg[FILT_STAGES-2:0], chan_in};
    out_next = out_reg;
    // Only a level seen on three edges in a row passes
    if (&hist_reg) begin
      out_next = 1'b1;
    end else if (~|hist_reg) begin
      out_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hist_reg <= FILT_RESET;
      out_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      out_reg <= out_next;
    end
  end

  assign chan_out = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_filter_stable;
    @(posedge clock) disable iff (srst)
      $changed(out_reg) |-> ($past(chan_in, 2) == out_reg && $past(chan_in, 3) == out_reg
                             && $past(chan_in, 4) == out_reg);
  endproperty
  a_filter_stable: assert property (p_filter_stable) else $error("filter output changed without three equal samples");

endmodule

`default_nettype wire

// ---- core/qpc_top.sv ----
// Quadrature position counter: filters, 4x decoder, 16-bit counter, latch, byte read port.
// Assumes encoder, output enable and byte select inputs are synchronous to clock.
`default_nettype none

module qpc_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic clear_n,
  input wire logic encoder_channel_a,
  input wire logic encoder_channel_b,
  input wire logic oe_n,
  input wire logic byte_sel,
  output logic [qpc_pkg::BYTE_W-1:0] read_bus,
  output logic read_bus_oe,
  output logic decoder_step_pulse,
  output logic count_up,
  output logic carry_borrow_pulse
);
  import qpc_pkg::*;

  logic filt_a;
  logic filt_b;
  logic [1:0] filt_ab;
  logic [1:0] prev_ab_reg;
  logic [1:0] prev_ab_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] latch_reg;
  logic [COUNT_W-1:0] latch_next;
  logic dir_reg;
  logic dir_next;
  logic step_pend_reg;
  logic step_pend_next;
  logic carry_pend_reg;
  logic carry_pend_next;
  logic step_reg;
  logic step_next;
  logic carry_reg;
  logic carry_next;
  logic [BYTE_W-1:0] bus_reg;
  logic [BYTE_W-1:0] bus_next;
  logic bus_oe_reg;
  logic bus_oe_next;
  qpc_inh_e inh_reg;
  qpc_inh_e inh_next;
  logic inhibit;
  logic step_det;
  logic step_up;

  ////////////////////////////////////////////////////////////////////////////
  // Input filters; the source must keep A and B in quadrature
  qpc_filter u_filt_a (
    .clock(clock),
    .srst(srst),
    .chan_in(encoder_channel_a),
    .chan_out(filt_a)
  );

  qpc_filter u_filt_b (
    .clock(clock),
    .srst(srst),
    .chan_in(encoder_channel_b),
    .chan_out(filt_b)
  );

  assign filt_ab = {filt_a, filt_b};

  ////////////////////////////////////////////////////////////////////////////
  // Decoder and counter
  assign step_det = (filt_ab != prev_ab_reg);
  // Illegal double changes count down; noise that gets this far miscounts anyway
  assign step_up = (filt_ab == qpc_next_up(prev_ab_reg));

  always_comb begin
    prev_ab_next = filt_ab;
    count_next = count_reg;
    dir_next = dir_reg;
    step_pend_next = 1'b0;
    carry_pend_next = 1'b0;
    if (step_det) begin
      step_pend_next = 1'b1;
      dir_next = step_up;
      // Counting goes on during reads so no step is lost
      if (step_up) begin
        count_next = count_reg + COUNT_ONE;
        carry_pend_next = (count_reg == COUNT_MAX);
      end else begin
        count_next = count_reg - COUNT_ONE;
        carry_pend_next = (count_reg == COUNT_RESET);
      end
    end
    // Pulses trail direction by one cycle so it is settled at their rise
    step_next = step_pend_reg;
    carry_next = carry_pend_reg;
  end

  // Clear is asynchronous and overrides the clock and every other input
  always_ff @(posedge clock or negedge clear_n) begin
    if (!clear_n) begin
      prev_ab_reg <= AB_RESET;
      count_reg <= COUNT_RESET;
      dir_reg <= 1'b0;
      step_pend_reg <= 1'b0;
      carry_pend_reg <= 1'b0;
      step_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else if (srst) begin
      prev_ab_reg <= AB_RESET;
      count_reg <= COUNT_RESET;
      dir_reg <= 1'b0;
      step_pend_reg <= 1'b0;
      carry_pend_reg <= 1'b0;
      step_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else begin
      prev_ab_reg <= prev_ab_next;
      count_reg <= count_next;
      dir_reg <= dir_next;
      step_pend_reg <= step_pend_next;
      carry_pend_reg <= carry_pend_next;
      step_reg <= step_next;
      carry_reg <= carry_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read inhibit, sampled on the falling edge so it is steady at the next rise
  always_comb begin
    inh_next = inh_reg;
    unique case (inh_reg)
      QPC_INH_IDLE: begin
        if (!oe_n && !byte_sel) begin
          inh_next = QPC_INH_HIGH;
        end
      end
      QPC_INH_HIGH: begin
        if (!oe_n && byte_sel) begin
          inh_next = QPC_INH_LOW;
        end
      end
      QPC_INH_LOW: begin
        if (oe_n) begin
          inh_next = QPC_INH_IDLE;
        end
      end
      default: inh_next = QPC_INH_IDLE;
    endcase
  end

  always_ff @(negedge clock or negedge clear_n) begin
    if (!clear_n) begin
      inh_reg <= QPC_INH_IDLE;
    end else if (srst) begin
      inh_reg <= QPC_INH_IDLE;
    end else begin
      inh_reg <= inh_next;
    end
  end

  assign inhibit = (inh_reg != QPC_INH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Position latch and byte port
  always_comb begin
    latch_next = inhibit ? latch_reg : count_reg;
    bus_next = qpc_byte(latch_reg, byte_sel);
    bus_oe_next = !oe_n;
  end

  always_ff @(posedge clock or negedge clear_n) begin
    if (!clear_n) begin
      latch_reg <= COUNT_RESET;
      bus_reg <= BYTE_RESET;
      bus_oe_reg <= 1'b0;
    end else if (srst) begin
      latch_reg <= COUNT_RESET;
      bus_reg <= BYTE_RESET;
      bus_oe_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      bus_reg <= bus_next;
      bus_oe_reg <= bus_oe_next;
    end
  end

  assign read_bus = bus_reg;
  assign read_bus_oe = bus_oe_reg;
  assign decoder_step_pulse = step_reg;
  assign count_up = dir_reg;
  assign carry_borrow_pulse = carry_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_step_seen;
    step_det ##1 step_pend_reg;
  endsequence

  sequence s_wrap_up;
    step_det && step_up && count_reg == COUNT_MAX;
  endsequence

  sequence s_wrap_down;
    step_det && !step_up && count_reg == COUNT_RESET;
  endsequence

  property p_clear_empty;
    @(posedge clock) disable iff (srst)
      $rose(clear_n) |-> (count_reg == COUNT_RESET && latch_reg == COUNT_RESET);
  endproperty
  a_clear_empty: assert property (p_clear_empty) else $error("counter or latch not empty after clear");

  property p_clear_idle;
    @(posedge clock) disable iff (srst)
      $rose(clear_n) |-> (inh_reg == QPC_INH_IDLE);
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("inhibit not idle after clear");

  property p_bus_release;
    @(posedge clock) disable iff (srst || !clear_n)
      oe_n [*2] |-> !read_bus_oe;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("read bus driven while enable high");

  property p_byte_pick;
    @(posedge clock) disable iff (srst || !clear_n)
      !oe_n |=> (read_bus_oe && read_bus == qpc_byte($past(latch_reg), $past(byte_sel)));
  endproperty
  a_byte_pick: assert property (p_byte_pick) else $error("wrong byte on read bus");

  property p_step_pulse;
    @(posedge clock) disable iff (srst || !clear_n)
      s_step_seen |=> decoder_step_pulse;
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("no step pulse after transition");

  property p_dir_ahead;
    @(posedge clock) disable iff (srst || !clear_n)
      ($rose(decoder_step_pulse) || $rose(carry_borrow_pulse)) |-> $stable(count_up);
  endproperty
  a_dir_ahead: assert property (p_dir_ahead) else $error("direction moved with a pulse rise");

  property p_count_up;
    @(posedge clock) disable iff (srst || !clear_n)
      (step_det && step_up) |=> (count_reg == $past(count_reg) + COUNT_ONE) ##1 count_up;
  endproperty
  a_count_up: assert property (p_count_up) else $error("up step did not increment");

  property p_carry;
    @(posedge clock) disable iff (srst || !clear_n)
      s_wrap_up |-> ##2 (carry_borrow_pulse && count_up);
  endproperty
  a_carry: assert property (p_carry) else $error("no carry on overflow");

  property p_latch_hold;
    @(posedge clock) disable iff (srst || !clear_n)
      inhibit |=> $stable(latch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch reloaded during a read");

  property p_latch_load;
    @(posedge clock) disable iff (srst || !clear_n)
      !inhibit |=> (latch_reg == $past(count_reg));
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch missed a reload");

  property p_count_down;
    @(posedge clock) disable iff (srst || !clear_n)
      (step_det && !step_up) |=> (count_reg == $past(count_reg) - COUNT_ONE) ##1 !count_up;
  endproperty
  a_count_down: assert property (p_count_down) else $error("down step did not decrement");

  property p_borrow;
    @(posedge clock) disable iff (srst || !clear_n)
      s_wrap_down |-> ##2 (carry_borrow_pulse && !count_up);
  endproperty
  a_borrow: assert property (p_borrow) else $error("no borrow on underflow");

  // Direction only moves with a decoded step
  property p_dir_hold;
    @(posedge clock) disable iff (srst || !clear_n)
      !step_det |=> $stable(count_up);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved without a step");

endmodule

`default_nettype wire

// ---- dv/qpc_encoder_model.sv ----
// Encoder stand-in driving the two quadrature channels.
// Assumes move and glitch change just after the rising clock edge.
`default_nettype none

module qpc_encoder_model (
  input wire logic clock,
  input wire logic move,
  input wire logic up,
  input wire logic glitch,
  output logic chan_a,
  output logic chan_b
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase_reg = 2'h0;

  always @(posedge clock) begin
    if (move) begin
      phase_reg <= up ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end
  end

  // Gray order 00,10,11,01 keeps A a quarter cycle ahead going up
  assign chan_a = phase_reg[0] ^ phase_reg[1] ^ glitch;
  assign chan_b = phase_reg[1];
endmodule

`default_nettype wire

// ---- dv/qpc_tb_top.sv ----
// Self-checking bench of the quadrature position counter.
// Assumes the encoder model beside it; the bench plays the reading processor.
`default_nettype none

module qpc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import qpc_pkg::*;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clear_n = 1'b1;
  logic oe_n = 1'b1;
  logic byte_sel = 1'b0;
  logic move = 1'b0;
  logic up = 1'b0;
  logic glitch = 1'b0;
  logic chan_a, chan_b, read_bus_oe, decoder_step_pulse, count_up, carry_borrow_pulse;
  logic [BYTE_W-1:0] read_bus;
  wire [BYTE_W-1:0] bus_wire;
  logic [COUNT_W-1:0] pos = 16'h0000;
  logic [COUNT_W-1:0] casc = 16'h0000;
  logic [COUNT_W-1:0] got;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;
  assign bus_wire = read_bus_oe ? read_bus : 8'hZZ;

  qpc_encoder_model qpc_encoder_model_inst (.clock(clock), .move(move), .up(up), .glitch(glitch),
    .chan_a(chan_a), .chan_b(chan_b));
  qpc_top qpc_top_inst (.clock(clock), .srst(srst), .clear_n(clear_n), .encoder_channel_a(chan_a),
    .encoder_channel_b(chan_b), .oe_n(oe_n), .byte_sel(byte_sel), .read_bus(read_bus),
    .read_bus_oe(read_bus_oe), .decoder_step_pulse(decoder_step_pulse), .count_up(count_up),
    .carry_borrow_pulse(carry_borrow_pulse));

  // Next cascaded stage
  always @(posedge carry_borrow_pulse) begin
    casc <= count_up ? casc + 16'h0001 : casc - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  // One encoder step; entered and left just after a rising edge
  task automatic step(input logic u);
    logic wrap;
    int n;
    wrap = u ? (pos == 16'hFFFF) : (pos == 16'h0000);
    move = 1'b1;
    up = u;
    @(posedge clock);
    #1 move = 1'b0;
    n = 0;
    while (decoder_step_pulse !== 1'b1 && n < 10) begin
      @(posedge clock);
      #1 n++;
    end
    check(decoder_step_pulse, 1'b1);
    check(count_up, u);
    check(carry_borrow_pulse, wrap);
    @(posedge clock);
    #1 check(decoder_step_pulse, 1'b0);
    pos = u ? pos + 16'h0001 : pos - 16'h0001;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // High byte, optional steps in mid read, then low byte
  task automatic read_pos(input int mid, output logic [15:0] v);
    oe_n = 1'b0;
    byte_sel = 1'b0;
    @(posedge clock);
    #1 check(read_bus_oe, 1'b1);
    v[15:8] = bus_wire;
    repeat (mid) step(1'b1);
    byte_sel = 1'b1;
    @(posedge clock);
    #1 v[7:0] = bus_wire;
    oe_n = 1'b1;
    @(posedge clock);
    #1 check(bus_wire, 8'hZZ);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_updown();
    repeat (4) step(1'b1);
    read_pos(0, got);
    check(got, pos);
    repeat (5) step(1'b0);
    check(casc, 16'hFFFF);
    read_pos(0, got);
    check(got, pos);
    step(1'b1);
    check(casc, 16'h0000);
    $display("test updown done");
  endtask

  task automatic t_freeze();
    read_pos(2, got);
    check(got, pos - 16'h0002);
    read_pos(0, got);
    check(got, pos);
    repeat (2) step(1'b1);
    $display("test freeze done");
  endtask

  task automatic t_glitch();
    glitch = 1'b1;
    repeat (2) @(posedge clock);
    #1 glitch = 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1 check(decoder_step_pulse, 1'b0);
    end
    // Three equal samples must pass: one step up, then one back down
    glitch = 1'b1;
    repeat (3) @(posedge clock);
    #1 glitch = 1'b0;
    repeat (3) @(posedge clock);
    #1 check(decoder_step_pulse, 1'b1);
    check(count_up, 1'b1);
    repeat (3) @(posedge clock);
    #1 check(decoder_step_pulse, 1'b1);
    check(count_up, 1'b0);
    @(posedge clock);
    #1 check(decoder_step_pulse, 1'b0);
    repeat (3) @(posedge clock);
    #1;
    $display("test glitch done");
  endtask

  // Clear lands while the latch is frozen by a high byte read
  task automatic t_clear();
    oe_n = 1'b0;
    byte_sel = 1'b0;
    @(posedge clock);
    #1 clear_n = 1'b0;
    #1 check(read_bus_oe, 1'b0);
    check(count_up, 1'b0);
    @(posedge clock);
    #1 clear_n = 1'b1;
    oe_n = 1'b1;
    pos = 16'h0000;
    @(posedge clock);
    #1 step(1'b1);
    read_pos(0, got);
    check(got, 16'h0001);
    $display("test clear done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    @(posedge clock);
    #1 t_updown();
    t_freeze();
    t_glitch();
    t_clear();
    give_verdict();
  end
endmodule

`default_nettype wire
